// ---- alc_pkg.sv ----
// Package for the angle latency compensation back end.
// Assumes a single 200 MHz clock and 14-bit angles.
package alc_pkg;
  localparam int          ANGLE_W        = 14;
  localparam int          MAG_W          = 14;
  localparam int          GAIN_W         = 8;
  localparam int          CORDIC_ITER    = 14;
  localparam int          CLK_MHZ        = 200;
  localparam int          PON_MS         = 10;
  localparam int          PON_CYCLES     = PON_MS * 1000 * CLK_MHZ;
  localparam int          SAMPLE_NS      = 222;
  localparam int          SAMPLE_CYCLES  = SAMPLE_NS * CLK_MHZ / 1000;
  localparam int          DELAY_US       = 100;
  localparam int          DELAY_SAMPLES  = (DELAY_US * 1000) / SAMPLE_NS;
  localparam int          RES_MIN        = 100;
  localparam int          RES_MAX        = 4096;
  localparam logic [13:0] ADDR_RAW       = 14'h3ffe;
  localparam logic [13:0] ADDR_CORR      = 14'h3fff;
  localparam logic [13:0] ADDR_MAG       = 14'h3ffd;
  localparam logic [7:0]  GAIN_RESET     = 8'h80;
  localparam logic [13:0] MAG_TARGET     = 14'h1000;
  localparam logic [11:0] PWM_PERIOD     = 12'hfff;
endpackage

// ---- alc_top.sv ----
// Angle back end: CORDIC, gain loop, lag correction, incremental,
// commutation and pulse-width outputs, plus a read port by address.
// Assumes sample pairs arrive synchronous to clk with a valid strobe.
//
// How it works
// - Each sample pair strobed while the CORDIC is idle is vectored by an iterative CORDIC into angle and magnitude.
// - The magnitude steers an up/down gain word that drives front-end amplification.
// - The full 14-bit angle is readable through the address read port.
// - Speed times the pipeline delay, in samples, gives the correction angle.
// - The raw angle carries the full core lag with no correction.
// - Incremental and commutation outputs follow the corrected angle when enabled.
// - The pulse-width output always carries the raw angle.
// - The disable input bypasses the correction on every output.
// - With commutation off, the third commutation pin carries the pulse-width angle.
// - Incremental resolution is chosen by a select input from 100 to 4096 steps.
// - The incremental counter steps one count per cycle toward target so no pulse is lost.
// - No angle is marked valid until the power-on interval has elapsed.
// - Raw and corrected angles sit at adjacent read addresses.
`timescale 1ns/1ps
module alc_top #(
  parameter int PON_CYC = alc_pkg::PON_CYCLES,
  parameter int POLES   = 1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Converted samples
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_x,
  input  wire logic [15:0] sample_y,
  // Configuration
  input  wire logic        lag_correction_disable,
  input  wire logic        commutation_off,
  input  wire logic [11:0] incremental_resolution_sel,
  // Read port
  input  wire logic [13:0] rd_addr,
  output logic      [13:0] rd_data,
  // Gain and status
  output logic      [7:0]  gain,
  output logic             angle_valid,
  // Pins
  output logic             quad_a,
  output logic             quad_b,
  output logic             quad_i,
  output logic             comm_u,
  output logic             comm_v,
  output logic             comm_w_pwm
);
  localparam int AW = alc_pkg::ANGLE_W;
  localparam int PW = 2 * alc_pkg::ANGLE_W;

  // CORDIC vectoring, one iteration per clock
  typedef enum logic [1:0] {ALC_IDLE, ALC_RUN, ALC_DONE} alc_state_t;
  alc_state_t     state_reg;
  logic signed [17:0] cx_reg, cy_reg;
  logic [15:0]    cz_reg;
  logic [3:0]     it_reg;
  logic [AW-1:0]  raw_reg, corr_reg, corr_next;
  logic [AW-1:0]  mag_reg;
  logic [AW-1:0]  speed_reg;
  logic [7:0]     gain_reg;

  // Arctangent table, 16-bit full turn
  function automatic logic [15:0] atan_lut(input logic [3:0] i);
    unique case (i)
      4'h0: atan_lut = 16'h2000;
      4'h1: atan_lut = 16'h12e4;
      4'h2: atan_lut = 16'h09fb;
      4'h3: atan_lut = 16'h0511;
      4'h4: atan_lut = 16'h028b;
      4'h5: atan_lut = 16'h0146;
      4'h6: atan_lut = 16'h00a3;
      4'h7: atan_lut = 16'h0051;
      4'h8: atan_lut = 16'h0029;
      4'h9: atan_lut = 16'h0014;
      4'ha: atan_lut = 16'h000a;
      4'hb: atan_lut = 16'h0005;
      4'hc: atan_lut = 16'h0003;
      default: atan_lut = 16'h0001;
    endcase
  endfunction

  // Pre-rotate into right half plane so the iterations converge
  wire               neg_x  = sample_x[15];
  wire signed [17:0] sx     = {{2{sample_x[15]}}, sample_x};
  wire signed [17:0] sy     = {{2{sample_y[15]}}, sample_y};
  wire signed [17:0] x0     = neg_x ? -sx : sx;
  wire signed [17:0] y0     = neg_x ? -sy : sy;
  wire [15:0]        z0     = neg_x ? 16'h8000 : 16'h0000;
  wire signed [17:0] xs     = cx_reg >>> it_reg;
  wire signed [17:0] ys     = cy_reg >>> it_reg;
  wire               rot_up = cy_reg[17];
  wire               last_it = (it_reg == 4'(alc_pkg::CORDIC_ITER - 1));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ALC_IDLE;
      cx_reg    <= 18'sh0;
      cy_reg    <= 18'sh0;
      cz_reg    <= 16'h0;
      it_reg    <= 4'h0;
    end
    else
    begin
      unique case (state_reg)
        ALC_IDLE:
          if (sample_valid)
          begin
            cx_reg    <= x0;
            cy_reg    <= y0;
            cz_reg    <= z0;
            it_reg    <= 4'h0;
            state_reg <= ALC_RUN;
          end
        ALC_RUN:
        begin
          cx_reg <= rot_up ? cx_reg - ys : cx_reg + ys;
          cy_reg <= rot_up ? cy_reg + xs : cy_reg - xs;
          cz_reg <= rot_up ? cz_reg - atan_lut(it_reg) : cz_reg + atan_lut(it_reg);
          it_reg <= it_reg + 4'h1;
          if (last_it)
            state_reg <= ALC_DONE;
        end
        ALC_DONE:
          state_reg <= ALC_IDLE;
        // Code 3 is unused; recover to idle
        default:
          state_reg <= ALC_IDLE;
      endcase
    end
  end

  wire done = (state_reg == ALC_DONE);

  // Modular speed and correction
  wire [AW-1:0] delta     = cz_reg[15:2] - raw_reg;
  // Only the low bits matter: the angle wraps, so the sign needs no care
  wire [PW-1:0] prod = PW'(speed_reg) * PW'(alc_pkg::DELAY_SAMPLES);
  wire [AW-1:0] correction = prod[AW-1:0];
  assign corr_next = lag_correction_disable ? raw_reg : raw_reg + correction;

  // Gain loop: current result, so the loop does not lag a sample
  wire [AW-1:0] mag_now = cx_reg[16:3];
  wire mag_low  = mag_now < alc_pkg::MAG_TARGET;
  wire gain_top = (gain_reg == 8'hff);
  wire gain_bot = (gain_reg == 8'h00);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      raw_reg   <= '0;
      mag_reg   <= '0;
      speed_reg <= '0;
      gain_reg  <= alc_pkg::GAIN_RESET;
    end
    else if (done)
    begin
      raw_reg   <= cz_reg[15:2];
      speed_reg <= delta;
      mag_reg   <= mag_now;
      if (mag_low && !gain_top)
        gain_reg <= gain_reg + 8'h01;
      else if (!mag_low && !gain_bot)
        gain_reg <= gain_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      corr_reg <= '0;
    else
      corr_reg <= corr_next;
  end

  // Power-on interval counter
  logic [31:0] pon_reg;
  wire pon_done = (pon_reg >= 32'(PON_CYC));
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pon_reg <= '0;
    else if (!pon_done)
      pon_reg <= pon_reg + 32'h1;
  end

  // Read port decode
  wire [AW-1:0] rd_next = (rd_addr == alc_pkg::ADDR_RAW)  ? raw_reg  :
                          (rd_addr == alc_pkg::ADDR_CORR) ? corr_reg :
                          (rd_addr == alc_pkg::ADDR_MAG)  ? mag_reg  : '0;

  // Incremental scaling: position = angle * res / 2^14
  wire [11:0] res_sel = (incremental_resolution_sel < 12'(alc_pkg::RES_MIN - 1)) ?
                        12'(alc_pkg::RES_MIN - 1) : incremental_resolution_sel;
  wire [12:0] steps   = 13'(res_sel) + 13'h1;
  wire [26:0] scaled  = 27'(corr_reg) * 27'(steps);
  wire [12:0] inc_tgt = scaled[26:14];
  logic [12:0] inc_reg;
  wire [12:0] inc_diff = inc_tgt - inc_reg;
  wire        inc_wrap = (inc_reg == steps - 13'h1);
  // One step per clock: far faster than rotation, so no step is skipped
  wire [12:0] inc_next = (inc_diff == 13'h0) ? inc_reg :
                         (inc_diff < (steps >> 1)) ? (inc_wrap ? 13'h0 : inc_reg + 13'h1) :
                         ((inc_reg == 13'h0) ? steps - 13'h1 : inc_reg - 13'h1);

  // Commutation sector from corrected angle
  wire [AW+2:0] pole_ang = 17'(corr_reg) * 17'(POLES);
  wire [16:0]   sect6    = 17'(pole_ang[AW-1:0]) * 17'h6;
  wire [2:0]    sector   = sect6[16:14];

  // Pulse-width: duty follows the raw angle, never corrected
  logic [11:0] pwm_cnt_reg;
  wire         pwm_level = pwm_cnt_reg < raw_reg[AW-1:2];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      inc_reg     <= '0;
      pwm_cnt_reg <= '0;
    end
    else
    begin
      inc_reg     <= inc_next;
      pwm_cnt_reg <= (pwm_cnt_reg == alc_pkg::PWM_PERIOD) ? 12'h0 : pwm_cnt_reg + 12'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data     <= '0;
      gain        <= alc_pkg::GAIN_RESET;
      angle_valid <= 1'b0;
      quad_a      <= 1'b0;
      quad_b      <= 1'b0;
      quad_i      <= 1'b0;
      comm_u      <= 1'b0;
      comm_v      <= 1'b0;
      comm_w_pwm  <= 1'b0;
    end
    else
    begin
      rd_data     <= pon_done ? rd_next : '0;
      gain        <= gain_reg;
      angle_valid <= pon_done;
      quad_a      <= inc_reg[1] ^ inc_reg[0];
      quad_b      <= inc_reg[1];
      quad_i      <= (inc_reg == 13'h0);
      comm_u      <= (sector < 3'h3);
      comm_v      <= (sector >= 3'h2) && (sector < 3'h5);
      comm_w_pwm  <= commutation_off ? pwm_level : ((sector >= 3'h4) || (sector == 3'h0));
    end
  end

  // Checks
  property p_valid_wait;
    @(posedge clk) disable iff (!rstn) !pon_done |=> !angle_valid;
  endproperty
  a_valid_wait: assert property (p_valid_wait) else $error("valid before power-on");

  property p_bypass;
    @(posedge clk) disable iff (!rstn) lag_correction_disable |=> corr_reg == $past(raw_reg);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not applied");

  property p_raw_read;
    @(posedge clk) disable iff (!rstn) pon_done && rd_addr == alc_pkg::ADDR_RAW |=> rd_data == $past(raw_reg);
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

  property p_cordic_len;
    @(posedge clk) disable iff (!rstn) state_reg == ALC_IDLE && sample_valid |=> ##14 done;
  endproperty
  a_cordic_len: assert property (p_cordic_len) else $error("cordic length wrong");

  property p_inc_step;
    @(posedge clk) disable iff (!rstn) inc_reg != $past(inc_reg) |-> inc_wrap || $past(inc_wrap) ||
      inc_reg == $past(inc_reg) + 13'h1 || inc_reg == $past(inc_reg) - 13'h1 || $past(inc_reg) == 13'h0;
  endproperty
  a_inc_step: assert property (p_inc_step) else $error("incremental jump");

  property p_pwm_off;
    @(posedge clk) disable iff (!rstn) commutation_off |=> comm_w_pwm == $past(pwm_level);
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm pin wrong");

  property p_gain_up;
    @(posedge clk) disable iff (!rstn) done && mag_low && !gain_top |=> gain_reg == $past(gain_reg) + 8'h01;
  endproperty
  a_gain_up: assert property (p_gain_up) else $error("gain did not rise");

  property p_gain_dn;
    @(posedge clk) disable iff (!rstn) done && !mag_low && !gain_bot |=> gain_reg == $past(gain_reg) - 8'h01;
  endproperty
  a_gain_dn: assert property (p_gain_dn) else $error("gain did not fall");

  property p_corr_wrap;
    @(posedge clk) disable iff (!rstn) !lag_correction_disable |=>
      corr_reg == AW'($past(raw_reg) + $past(correction));
  endproperty
  a_corr_wrap: assert property (p_corr_wrap) else $error("corrected angle wrong");

  c_valid: cover property (@(posedge clk) disable iff (!rstn) $rose(angle_valid));
  c_pwm:   cover property (@(posedge clk) disable iff (!rstn) commutation_off && comm_w_pwm);
  c_done:  cover property (@(posedge clk) disable iff (!rstn) done);
  c_comm:  cover property (@(posedge clk) disable iff (!rstn) !commutation_off && comm_u && comm_w_pwm);
endmodule

// ---- alc_host_model.sv ----
// Host side model: counts quadrature edges and flags double jumps.
// Assumes quad_a and quad_b are registered levels in the clk domain.
`timescale 1ns/1ps
module alc_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Quadrature pins
  input  wire logic        quad_a,
  input  wire logic        quad_b,
  // Edge count and lost-step flag
  output logic      [15:0] steps,
  output logic             lost
);
  logic [1:0] ab_reg;
  wire  [1:0] ab_now = {quad_a, quad_b};
  // Both bits at once means a step was skipped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ab_reg <= 2'h0;
      steps  <= 16'h0;
      lost   <= 1'b0;
    end
    else
    begin
      ab_reg <= ab_now;
      if (ab_now != ab_reg)
        steps <= steps + 16'h1;
      if ((ab_now ^ ab_reg) == 2'h3)
        lost <= 1'b1;
    end
  end
endmodule

// ---- tb_top.sv ----
// Bench for the angle back end: power-on, CORDIC, gain, correction, outputs.
// Assumes a short power-on count and samples 22 cycles apart.
`timescale 1ns/1ps
module tb_top;
  localparam int PON = 50;
  logic        clk;
  logic        rstn;
  logic        sample_valid;
  logic [15:0] sample_x;
  logic [15:0] sample_y;
  logic        lag_correction_disable;
  logic        commutation_off;
  logic [11:0] incremental_resolution_sel;
  logic [13:0] rd_addr;
  logic [13:0] rd_data;
  logic [7:0]  gain;
  logic        angle_valid;
  logic        quad_a;
  logic        quad_b;
  logic        quad_i;
  logic        comm_u;
  logic        comm_v;
  logic        comm_w_pwm;
  logic [15:0] steps;
  logic        lost;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  alc_top #(.PON_CYC(PON)) uut (.clk(clk), .rstn(rstn), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .lag_correction_disable(lag_correction_disable), .commutation_off(commutation_off),
    .incremental_resolution_sel(incremental_resolution_sel), .rd_addr(rd_addr), .rd_data(rd_data),
    .gain(gain), .angle_valid(angle_valid), .quad_a(quad_a), .quad_b(quad_b), .quad_i(quad_i),
    .comm_u(comm_u), .comm_v(comm_v), .comm_w_pwm(comm_w_pwm));
  alc_host_model host (.clk(clk), .rstn(rstn), .quad_a(quad_a), .quad_b(quad_b), .steps(steps), .lost(lost));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is about 18k cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Modular distance, since CORDIC rounding is not bit exact
  task automatic near(string what, int exp, logic [13:0] got, int tol);
    int d;
    n_tests++;
    d = (int'(got) - exp) & 16'h3fff;
    if (d > 8192)
      d = 16384 - d;
    if ($isunknown(got) || d > tol)
    begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic put(int a, real amp);
    real th;
    th = a * 6.283185307 / 16384.0;
    @(posedge clk) #1;
    sample_valid = 1'b1;
    sample_x = 16'($rtoi(amp * $cos(th)));
    sample_y = 16'($rtoi(amp * $sin(th)));
    @(posedge clk) #1;
    sample_valid = 1'b0;
    repeat (20) @(posedge clk) #1;
  endtask
  task automatic rd(logic [13:0] addr, output logic [13:0] got);
    @(posedge clk) #1;
    rd_addr = addr;
    @(posedge clk) #1;
    got = rd_data;
  endtask
  task automatic t_power_on;
    logic [13:0] v;
    int n;
    chk("gain", 16'h80, {8'h0, gain});
    chk("valid", 16'h0, {15'h0, angle_valid});
    rd(14'h3ffe, v);
    chk("early_raw", 16'h0, {2'h0, v});
    for (n = 2; n < 300 && angle_valid !== 1'b1; n++)
      @(posedge clk) #1;
    near("pon", PON, 14'(n), 3);
  endtask
  task automatic t_cordic_gain;
    logic [13:0] v;
    put(32'h1000, 200.0);
    chk("gain_up", 16'h81, {8'h0, gain});
    rd(14'h3ffe, v);
    near("raw", 32'h1000, v, 8);
    // Strong field twice at one angle, so speed is exactly zero
    put(32'h1000, 24000.0);
    chk("gain_dn", 16'h80, {8'h0, gain});
    put(32'h1000, 24000.0);
    rd(14'h3fff, v);
    near("corr_still", 32'h1000, v, 8);
    rd(14'h3ffc, v);
    chk("unmapped", 16'h0, {2'h0, v});
  endtask
  // Crosses zero so a non-modular speed would blow up
  task automatic t_rotation;
    logic [13:0] v;
    for (int k = 0; k < 5; k++)
      put((16300 + 30 * k) % 16384, 6000.0);
    rd(14'h3ffe, v);
    near("raw_rot", 36, v, 8);
    rd(14'h3fff, v);
    near("corr_rot", (36 + 30 * 450) % 16384, v, 1000);
  endtask
  task automatic t_pwm;
    int hi = 0;
    commutation_off = 1'b1;
    repeat (4096) @(posedge clk);
    repeat (4096)
    begin
      @(posedge clk) #1;
      hi += (comm_w_pwm === 1'b1);
    end
    near("pwm_duty", 9, 14'(hi), 3);
    commutation_off = 1'b0;
  endtask
  task automatic t_quad(logic [11:0] sel, int a, int exp);
    logic [15:0] s0;
    incremental_resolution_sel = sel;
    repeat (3000) @(posedge clk) #1;
    s0 = steps;
    put(a, 6000.0);
    repeat (1500) @(posedge clk) #1;
    near("quad", exp, 14'(steps - s0), 2);
    chk("lost", 16'h0, {15'h0, lost});
  endtask
  // Six-step pattern {u,v,w}: 011 at 270 degrees, 101 near zero
  task automatic t_comm;
    chk("uvw_270", 16'h3, {13'h0, comm_u, comm_v, comm_w_pwm});
    chk("index_off", 16'h0, {15'h0, quad_i});
    put(60, 6000.0);
    repeat (200) @(posedge clk) #1;
    chk("uvw_0", 16'h5, {13'h0, comm_u, comm_v, comm_w_pwm});
    chk("index_on", 16'h1, {15'h0, quad_i});
  endtask
  initial
  begin
    rstn = 1'b0;
    sample_valid = 1'b0;
    sample_x = 16'h0;
    sample_y = 16'h0;
    lag_correction_disable = 1'b0;
    commutation_off = 1'b0;
    incremental_resolution_sel = 12'hfff;
    rd_addr = 14'h0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    t_power_on();
    t_cordic_gain();
    t_rotation();
    t_pwm();
    lag_correction_disable = 1'b1;
    put(32'h1000, 6000.0);
    t_quad(12'hfff, 32'h2000, 1024);
    t_quad(12'h063, 32'h3000, 25);
    t_comm();
    wrap_up();
  end
endmodule
